// [hdl/scp_host.sv]
// Host controller that drives the serial mode control port of the converter
`include "scp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module scp_host
	import scp_pkg::*;
#(
	parameter int SHIFT_HALF_NS = `SCP_SHIFT_HALF_NS
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// User command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_read,
	input wire logic i_cmd_auto,
	input wire logic [6:0] i_cmd_index,
	input wire logic [7:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_busy,
	output logic o_done,
	// Read answer port
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic [6:0] o_rd_index,
	// Device control pins
	output logic o_frame_latch_strobe,
	output logic o_control_shift_clock,
	output logic o_control_serial_in,
	input wire logic i_control_serial_out
);

	// Half period of the shift clock in system cycles, rounded up. A floor applies because the
	// readback pin needs two synchroniser cycles plus one of margin before it is sampled.
	// Limitation: the divider is eight bits wide, so a half period cannot exceed 256 cycles.
	localparam int HALF_RAW = (SHIFT_HALF_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS;
	localparam int HALF_CYC = (HALF_RAW < `SCP_MIN_HALF_CYC) ? `SCP_MIN_HALF_CYC : HALF_RAW;
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [10:0] WORD_LAST = 11'(`SCP_WORD_BITS - 1);

	// Registered state and the value it takes at the next edge
	scp_host_state_t cur;
	scp_host_state_t next_cur;

	// Decoded timing, framing and data values shared by the sequencer
	logic in_frame;
	logic take_cmd;
	logic half_tick;
	logic last_clock;
	logic in_answer;
	logic byte_end;
	logic next_bit;
	logic [7:0] assembled;
	logic [7:0] next_div;
	logic [10:0] next_clk_cnt;
	logic [6:0] next_rd_index;
	logic [15:0] shifted_word;
	logic [15:0] write_word;
	logic [15:0] readback_word;
	logic [15:0] read_word;
	logic [10:0] run_last_cnt;
	logic [6:0] first_index;

	// A frame or the gap after it is in progress whenever the sequencer is not idle
	assign in_frame = (cur.st != SCP_IDLE);

	// A command is taken only while idle; requests during a frame are simply not looked at
	assign take_cmd = (cur.st == SCP_IDLE) && i_cmd_valid;

	// Every pin change except the strobe fall that opens a command happens on the cycle the divider wraps,
	// so each level on the link lasts a full half period
	assign half_tick = (cur.div == HALF_LAST);

	// The final shift clock of the frame has just finished its high phase
	assign last_clock = (cur.clk_cnt == cur.last_cnt);

	// Answer bits come after the eight clocks that carry the read word's upper byte
	assign in_answer = cur.is_read && (cur.clk_cnt >= `SCP_RESP_SKIP_BITS);

	// Every eighth answer bit closes one register byte
	assign byte_end = (cur.clk_cnt[2:0] == 3'h7);

	// The outgoing word is sent from its top bit down
	assign next_bit = cur.word[`SCP_DIR_BIT];

	// Byte assembled MSB first from the synchroniser's second stage only
	assign assembled = {cur.rd_shift[6:0], cur.sync2};

	// Half-period divider wraps to zero at the end of each half period
	assign next_div = half_tick ? 8'h00 : cur.div + 8'h01;

	// Shift clocks of the frame counted from zero
	assign next_clk_cnt = cur.clk_cnt + 11'h001;

	// Index of the byte after the one just completed
	assign next_rd_index = cur.rd_index + 7'h01;

	// Outgoing word moves up one place per clock;
	// zeros trail it in long read frames and the device ignores them
	assign shifted_word = {cur.word[14:0], 1'b0};

	// Plain write: direction, index, payload
	assign write_word = {`SCP_DIR_WRITE, i_cmd_index, i_cmd_data};

	// A read first writes the readback control with the target or the last index,
	// auto-increment cleared for a single read and set for a run
	assign readback_word = {`SCP_DIR_WRITE, `SCP_READBACK_CTRL, i_cmd_auto, i_cmd_index};

	// The read word carries an all-zero index; the device picks its own from the readback control
	assign read_word = {`SCP_DIR_READ, `SCP_READ_IDX, 8'h00};

	// A run takes eight idle clocks and then one byte per register up to the last one;
	// a single read is one plain word long
	assign run_last_cnt = cur.pend_auto ? {1'b0, cur.pend_index, 3'h7} : WORD_LAST;

	// The first byte of a run is the first channel's attenuation, of a single read the target
	assign first_index = cur.pend_auto ? `SCP_CHANNEL1_ATTENUATION : cur.pend_index;

	// Frame shape, with H the half period in system cycles:
	//   strobe falls, H cycles later the shift clock falls with bit 15 on the serial input;
	//   the clock then alternates every H cycles, each rise carrying one bit into the device;
	//   after the last rise the clock stays high for H cycles, the strobe rises, and after
	//   another H cycles the next frame opens or the command completes.
	// Answers are sampled in the cycle the clock goes high, from the synchroniser's second
	// stage, so the device has H minus two cycles after its falling edge to settle the pin.
	// Trade-off: a fixed divider keeps the pins simple and glitch free at the cost of a
	// slower link than the device could take.
	always_comb begin
		next_cur = cur;
		// Answer pulses last one cycle
		next_cur.rd_valid = 1'b0;
		next_cur.done = 1'b0;
		// Readback pin comes from the device's own timing, so it passes two flip-flops first
		next_cur.sync1 = i_control_serial_out;
		next_cur.sync2 = cur.sync1;
		// Half-period divider runs whenever a frame is in progress
		if (in_frame) begin
			next_cur.div = next_div;
		end
		// One arm per phase of the frame
		unique case (cur.st)
			SCP_IDLE: begin
				// Divider parked so every frame starts with a full half period
				next_cur.div = 8'h00;
				if (take_cmd) begin
					// Command taken: open the first frame by pulling the strobe low
					next_cur.clk_cnt = 11'h000;
					next_cur.last_cnt = WORD_LAST;
					next_cur.is_read = 1'b0;
					next_cur.read_pend = i_cmd_read;
					next_cur.pend_auto = i_cmd_auto;
					next_cur.pend_index = i_cmd_index;
					next_cur.strobe = 1'b0;
					next_cur.st = SCP_SETUP;
					if (i_cmd_read) begin
						next_cur.word = readback_word;
					end else begin
						next_cur.word = write_word;
					end
				end
			end

			SCP_SETUP: begin
				// Strobe low for a half period before the first falling shift edge
				if (half_tick) begin
					next_cur.sclk = 1'b0;
					next_cur.sdi = next_bit;
					next_cur.word = shifted_word;
					next_cur.st = SCP_LOW;
				end
			end

			SCP_LOW: begin
				// Rising edge: the device takes our bit; its answer has been stable since the fall
				if (half_tick) begin
					next_cur.sclk = 1'b1;
					next_cur.st = SCP_HIGH;
					// Only answer clocks of a read frame feed the shift register
					if (in_answer) begin
						next_cur.rd_shift = assembled;
						if (byte_end) begin
							// Byte complete: hand it out with the index it came from
							next_cur.rd_data = assembled;
							next_cur.out_index = cur.rd_index;
							next_cur.rd_valid = 1'b1;
							next_cur.rd_index = next_rd_index;
						end
					end
				end
			end

			SCP_HIGH: begin
				// End of a high phase: either the frame is over or the next bit goes out
				if (half_tick) begin
					if (last_clock) begin
						// Strobe rises right after the final clock; the device latches then
						next_cur.strobe = 1'b1;
						next_cur.st = SCP_HOLD;
					end else begin
						// Next falling edge puts out the next bit
						next_cur.clk_cnt = next_clk_cnt;
						next_cur.sclk = 1'b0;
						next_cur.sdi = next_bit;
						next_cur.word = shifted_word;
						next_cur.st = SCP_LOW;
					end
				end
			end

			SCP_HOLD: begin
				// Strobe high for a half period, then the read frame or completion
				if (half_tick) begin
					if (cur.read_pend) begin
						// Read frame opens on this strobe fall, right after the readback control write
						// so no other frame can move the device's readback index in between
						next_cur.read_pend = 1'b0;
						next_cur.is_read = 1'b1;
						next_cur.clk_cnt = 11'h000;
						next_cur.word = read_word;
						next_cur.last_cnt = run_last_cnt;
						next_cur.rd_index = first_index;
						next_cur.strobe = 1'b0;
						next_cur.st = SCP_SETUP;
					end else begin
						// Command finished: ready returns together with the done pulse
						next_cur.is_read = 1'b0;
						next_cur.done = 1'b1;
						next_cur.st = SCP_IDLE;
					end
				end
			end
		endcase
	end

	// State register. Reset parks the pins idle: strobe and shift clock high, serial input low.
	// The reset value of every field is spelled out, all of them constants.
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			cur.st <= SCP_IDLE;
			cur.div <= 8'h00;
			cur.clk_cnt <= 11'h000;
			cur.last_cnt <= 11'h000;
			cur.word <= 16'h0000;
			cur.rd_shift <= 8'h00;
			cur.strobe <= 1'b1;
			cur.sclk <= 1'b1;
			cur.sdi <= 1'b0;
			cur.sync1 <= 1'b0;
			cur.sync2 <= 1'b0;
			cur.is_read <= 1'b0;
			cur.read_pend <= 1'b0;
			cur.pend_auto <= 1'b0;
			cur.pend_index <= 7'h00;
			cur.rd_index <= 7'h00;
			cur.rd_data <= 8'h00;
			cur.out_index <= 7'h00;
			cur.rd_valid <= 1'b0;
			cur.done <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// Command port handshake, combinational from the state
	assign o_cmd_ready = (cur.st == SCP_IDLE);
	assign o_busy = (cur.st != SCP_IDLE);

	// Completion and answer outputs come straight from flip-flops
	assign o_done = cur.done;
	assign o_rd_valid = cur.rd_valid;
	assign o_rd_data = cur.rd_data;
	assign o_rd_index = cur.out_index;

	// Device pins: strobe frames, shift clock moves bits, serial input carries words
	// All three leave flip-flops, so no glitch reaches the device's edge-sensitive port
	assign o_frame_latch_strobe = cur.strobe;
	assign o_control_shift_clock = cur.sclk;
	assign o_control_serial_in = cur.sdi;

endmodule

`default_nettype wire

// [hdl/scp_pkg.sv]
// Types of the serial mode control port host
package scp_pkg;

	// Frame sequencer states
	typedef enum logic [2:0] {
		SCP_IDLE,
		SCP_SETUP,
		SCP_LOW,
		SCP_HIGH,
		SCP_HOLD
	} scp_state_t;

	// Whole state of the host controller
	typedef struct packed {
		scp_state_t st;
		logic [7:0] div;
		logic [10:0] clk_cnt;
		logic [10:0] last_cnt;
		logic [15:0] word;
		logic [7:0] rd_shift;
		logic strobe;
		logic sclk;
		logic sdi;
		logic sync1;
		logic sync2;
		logic is_read;
		logic read_pend;
		logic pend_auto;
		logic [6:0] pend_index;
		logic [6:0] rd_index;
		logic [7:0] rd_data;
		logic [6:0] out_index;
		logic rd_valid;
		logic done;
	} scp_host_state_t;

endpackage

// [hdl/scp_regs.svh]
// Offsets, field positions, reset values and timing figures of the serial mode control port
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Control word layout
`define SCP_WORD_BITS 16
`define SCP_DIR_BIT 15
`define SCP_IDX_MSB 14
`define SCP_IDX_LSB 8
`define SCP_DATA_BITS 8
`define SCP_DIR_WRITE 1'h0
`define SCP_DIR_READ 1'h1
`define SCP_READ_IDX 7'h00
`define SCP_RESP_SKIP_BITS 11'h008

// Register indices of the device
`define SCP_PLACEHOLDER_SLOT 7'h00
`define SCP_CHANNEL1_ATTENUATION 7'h01
`define SCP_CHANNEL2_ATTENUATION 7'h02
`define SCP_CHANNEL3_ATTENUATION 7'h03
`define SCP_CHANNEL4_ATTENUATION 7'h04
`define SCP_CHANNEL5_ATTENUATION 7'h05
`define SCP_CHANNEL6_ATTENUATION 7'h06
`define SCP_ATTENUATION_AND_MUTE_CTRL 7'h07
`define SCP_CHANNEL_ENABLE_CTRL 7'h08
`define SCP_FORMAT_FILTER_CLOCKOUT_CTRL 7'h09
`define SCP_EMPHASIS_PHASE_CTRL 7'h0a
`define SCP_READBACK_CTRL 7'h0b
`define SCP_OVERSAMPLE_AND_GP_OUTPUT_CTRL 7'h0c

// Field positions
`define SCP_ATTENUATION_LOAD_ENABLE_BIT 7
`define SCP_ATTENUATION_STEP_RATE_BIT 6
`define SCP_ZERO_DETECT_MUTE_ENABLE_BIT 6
`define SCP_ROLLOFF_SELECT_BIT 5
`define SCP_CLOCK_OUTPUT_DIVIDE_BIT 4
`define SCP_CLOCK_OUTPUT_ENABLE_BIT 3
`define SCP_OUTPUT_PHASE_INVERT_BIT 5
`define SCP_OVERSAMPLE_SELECT_BIT 7
`define SCP_GENERAL_OUTPUT_SELECT_BIT 6
`define SCP_READBACK_AUTO_INC_BIT 7

// Reset values known for the device registers
`define SCP_RST_ATTENUATION 8'hff
`define SCP_RST_ATTENUATION_AND_MUTE 8'h00
`define SCP_RST_CHANNEL_ENABLE 8'h00
`define SCP_RST_READBACK_CTRL 8'h01

// Timing figures
`define SCP_CLK_PERIOD_NS 10
`define SCP_SHIFT_HALF_NS 40
`define SCP_MIN_HALF_CYC 3

`endif

// [verification/scp_dev_model.sv]
// Behavioural converter control port: register file and serial pins
`timescale 1ns/1ns
`default_nettype none
module scp_dev_model (
	// Control pins
	input wire logic i_stb,
	input wire logic i_sck,
	input wire logic i_sdi,
	output logic o_sdo
);
	logic [7:0] rg[13];
	logic [15:0] sh;
	logic [7:0] ob;
	logic [6:0] ri;
	logic rd;
	int n;
	// Defaults; 9, 10 and 12 taken as zero
	initial begin
		foreach (rg[i]) rg[i] = (i > 0 && i < 7) ? 8'hff : 8'h00;
		rg[11] = 8'h01;
		o_sdo = 1'b0;
	end
	// Strobe fall opens a frame and picks the first index
	always @(negedge i_stb) begin
		n = 0;
		ri = rg[11][7] ? 7'h01 : rg[11][6:0];
	end
	// Input taken on the rising edge
	always @(posedge i_sck) begin
		if (!i_stb) begin
			sh = {sh[14:0], i_sdi};
			n++;
			if (n == 1) rd = i_sdi;
		end
	end
	// Released line shows the inverse of its last level, so a stale bit never passes
	always @(negedge i_sck) begin
		if (!i_stb && rd && n >= 8) begin
			if (n % 8 == 0) ob = (ri > 0 && ri < 13) ? rg[ri] : 8'h00;
			else ob = ob << 1;
			if (n % 8 == 0) ri++;
			o_sdo = ob[7];
		end else o_sdo = ~o_sdo;
	end
	// Commit on the strobe rise, reserved bits stay zero
	always @(posedge i_stb) begin
		if (n == 16 && !rd && sh[14:8] > 0 && sh[14:8] < 13)
			rg[sh[14:8]] = sh[7:0] & (sh[14:8] == 8 ? 8'h7f : sh[14:8] == 9 || sh[14:8] == 10 ? 8'h3f : 8'hff);
		o_sdo = ~o_sdo;
	end
endmodule
`default_nettype wire

// [verification/scp_host_chk.sv]
// Assertions on the host's command port and control pins
`timescale 1ns/1ns
`default_nettype none
module scp_host_chk (
	// Clock, reset, command port
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic o_cmd_ready,
	input wire logic o_done,
	// Control pins
	input wire logic o_frame_latch_strobe,
	input wire logic o_control_shift_clock,
	input wire logic o_control_serial_in
);
	logic [10:0] cnt;
	logic dir;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// Rising shift edges in the frame and its direction bit
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n || o_frame_latch_strobe) cnt <= 11'h000;
		else if ($rose(o_control_shift_clock)) cnt <= cnt + 11'h001;
		if (!i_reset_n) dir <= 1'b0;
		else if (!o_frame_latch_strobe && $rose(o_control_shift_clock) && cnt == 11'h000) dir <= o_control_serial_in;
	end
	chk_idle_pins: assert property (o_cmd_ready |-> o_frame_latch_strobe && o_control_shift_clock)
		else $error("pins not idle");
	chk_clock_framed: assert property ($fell(o_control_shift_clock) |-> !o_frame_latch_strobe)
		else $error("clock outside frame");
	chk_data_on_fall: assert property (!o_frame_latch_strobe && $changed(o_control_serial_in)
		|-> $fell(o_control_shift_clock)) else $error("data moved off falling edge");
	chk_write_sixteen: assert property ($rose(o_frame_latch_strobe) && !dir |-> cnt == 11'h010)
		else $error("write frame length");
	chk_read_bytes: assert property ($rose(o_frame_latch_strobe) && dir |-> cnt[2:0] == 3'h0 && cnt >= 11'h008)
		else $error("read frame length");
	chk_read_zeros: assert property ($rose(o_control_shift_clock) && dir && cnt != 11'h000 |-> !o_control_serial_in)
		else $error("read word not zero");
	chk_done_pulse: assert property (o_done |=> !o_done)
		else $error("done too long");
	chk_ready_done: assert property ($rose(o_cmd_ready) |-> o_done)
		else $error("ready without done");
	cov_write: cover property ($rose(o_frame_latch_strobe) && !dir);
	cov_single: cover property ($rose(o_frame_latch_strobe) && dir && cnt == 11'h010);
	cov_auto: cover property ($rose(o_frame_latch_strobe) && dir && cnt > 11'h010);
endmodule
bind scp_host scp_host_chk scp_host_chk_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_frame_latch_strobe(o_frame_latch_strobe),
	.o_control_shift_clock(o_control_shift_clock), .o_control_serial_in(o_control_serial_in));
`default_nettype wire

// [verification/scp_host_tb.sv]
// Self-checking bench: host controller against a behavioural converter port
`timescale 1ns/1ns
`default_nettype none
module scp_host_tb;
	logic clk, rst_n, vld, rd, au, dn, rv, stb, sck, sdi, sdo, rdy, bsy;
	logic [6:0] ix, ri;
	logic [7:0] dt, rdd;
	logic [7:0] qd[$];
	logic [6:0] qi[$];
	int bad_count, comparisons;
	// Write table: index, payload, value read back after masking
	logic [22:0] wt[5] = '{{7'h07, 16'ha5a5}, {7'h08, 16'hff7f}, {7'h09, 16'hff3f}, {7'h0c, 16'hc3c3}, {7'h20, 16'h7700}};
	scp_host #(.SHIFT_HALF_NS(30)) scp_host_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cmd_valid(vld),
		.i_cmd_read(rd), .i_cmd_auto(au), .i_cmd_index(ix), .i_cmd_data(dt), .o_cmd_ready(rdy), .o_busy(bsy),
		.o_done(dn), .o_rd_valid(rv), .o_rd_data(rdd), .o_rd_index(ri), .o_frame_latch_strobe(stb),
		.o_control_shift_clock(sck), .o_control_serial_in(sdi), .i_control_serial_out(sdo));
	scp_dev_model scp_dev_model_inst (.i_stb(stb), .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Returned bytes sampled away from the edge that launches them
	always @(negedge clk) begin
		if (rv === 1'b1) begin
			qd.push_back(rdd);
			qi.push_back(ri);
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One command, then a bounded wait for done
	task automatic cmd(input logic r, input logic a, input logic [6:0] i, input logic [7:0] d);
		int t;
		t = 0;
		qd.delete();
		qi.delete();
		{vld, rd, au, ix, dt} = {1'b1, r, a, i, d};
		@(posedge clk);
		#1;
		vld = 1'b0;
		@(negedge clk);
		chk({7'h00, bsy}, 8'h01);
		while (dn !== 1'b1 && t < 5000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 5000) begin
			bad_count++;
			wrap_up();
		end
		chk({7'h00, rdy}, 8'h01);
		@(posedge clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{rst_n, vld, rd, au, ix, dt} = '0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cmd(1'b1, 1'b1, 7'h0c, 8'h00);
		chk(8'(qd.size()), 8'h0c);
		for (int i = 0; i < 12; i++) begin
			chk(qd[i], i < 6 ? 8'hff : i == 10 ? 8'h8c : 8'h00);
			chk({1'b0, qi[i]}, 8'(i + 1));
		end
		$display("reset readback done");
		for (int i = 0; i < 5; i++) begin
			cmd(1'b0, 1'b0, wt[i][22:16], wt[i][15:8]);
			cmd(1'b1, 1'b0, wt[i][22:16], 8'h00);
			chk(8'(qd.size()), 8'h01);
			chk(qd[0], wt[i][7:0]);
			chk({1'b0, qi[0]}, {1'b0, wt[i][22:16]});
		end
		$display("write and single read done");
		cmd(1'b1, 1'b1, 7'h00, 8'h00);
		chk(8'(qd.size()), 8'h00);
		$display("empty auto read done");
		wrap_up();
	end
	// Watchdog well beyond the expected span of about 2500 cycles
	initial begin
		#300000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
